// ==== rtl/flash_regs_pkg.sv ====
// shared constants and carrier types for the flash function and read parameter registers
// assumes every user refers to these names through the package scope
package flash_regs_pkg;

   // ----------------------------------------
   // command opcodes seen on the serial link
   // ----------------------------------------
   localparam logic [7:0] OP_PARAMS_PERSIST = 8'h65;
   localparam logic [7:0] OP_PARAMS_TEMP_A  = 8'hC0;
   localparam logic [7:0] OP_PARAMS_TEMP_B  = 8'h63;
   localparam logic [7:0] OP_WRITE_FUNC     = 8'h42;

   // ----------------------------------------
   // layouts, reset values and masks
   // ----------------------------------------
   localparam logic [7:0] FUNC_RESET    = 8'h00;
   localparam logic [7:0] FUNC_OTP_MASK = 8'hF3; // suspend flags at bits 3:2 are read only
   localparam logic [7:0] FUNC_RST_DIS  = 8'h01; // reset-disable bit at bit 0
   localparam logic [7:0] PARAMS_RESET  = 8'h00;

   // ----------------------------------------
   // dummy cycle defaults and burst sizes
   // ----------------------------------------
   localparam logic [3:0] DUMMY_USE_DEFAULT = 4'h0;
   localparam logic [3:0] DUMMY_SINGLE      = 4'h8;
   localparam logic [3:0] DUMMY_QUAD        = 4'h6;
   localparam logic [3:0] DUMMY_DUAL_IO     = 4'h4;
   localparam logic [6:0] BURST_MIN_BYTES   = 7'h08;
   localparam logic [6:0] WRAP_WHOLE_ARRAY  = 7'h00;

   // ----------------------------------------
   // timing counts
   // ----------------------------------------
   localparam logic [4:0] FRAME_BITS   = 5'h10; // opcode byte plus data byte
   localparam logic [4:0] OPCODE_LAST  = 5'h07;
   localparam logic [4:0] DATA_LAST    = 5'h0F;
   localparam logic [1:0] INIT_CYCLES  = 2'h3;  // covers the pin synchroniser latency

   // ----------------------------------------
   // carrier types
   // ----------------------------------------
   typedef struct packed {
      logic [3:0] infoRowLock;
      logic       erasePausedFlag;
      logic       programPausedFlag;
      logic       protectAreaSideSelect;
      logic       resetPinDisable;
   } func_reg_t;

   typedef struct packed {
      logic       sharedPinFunctionSelect;
      logic [3:0] dummyCycles;
      logic       wrapEnable;
      logic [1:0] burstLength;
   } read_param_t;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] data;
   } link_cmd_t;

   typedef enum logic [2:0] {
      RK_FAST_SINGLE,
      RK_FAST_FOUR_LANE,
      RK_DUAL_OUT,
      RK_DUAL_IO,
      RK_QUAD_OUT,
      RK_QUAD_IO
   } read_kind_t;

endpackage

// ==== rtl/link_cmd_capture.sv ====
// serial-clock side: shifts in one opcode byte and one data byte per frame
// assumes mode 0 sampling on rising sck and that sck stands still outside frames
`timescale 1ns/1ps
module link_cmd_capture (
   input  wire logic                      sck,
   input  wire logic                      rst_n,
   input  wire logic                      csN,
   input  wire logic                      si,
   output flash_regs_pkg::link_cmd_t      cmd,
   output logic                           cmdToggle
);

   // ----------------------------------------
   // bit counting inside a frame
   // ----------------------------------------
   logic [4:0] bitCnt_q;
   logic [6:0] shift_q;
   logic [7:0] opcode_q;
   wire        frameClr_n = rst_n & ~csN; // the frame's own end clears the count
   wire        countFull  = (bitCnt_q == flash_regs_pkg::FRAME_BITS);
   wire        opcodeDone = (bitCnt_q == flash_regs_pkg::OPCODE_LAST);
   wire        dataDone   = (bitCnt_q == flash_regs_pkg::DATA_LAST);
   wire [7:0]  byteIn     = {shift_q, si};

   // saturate so extra bits in a long frame never start a second command
   always_ff @(posedge sck or negedge frameClr_n) begin
      if (!frameClr_n) begin
         bitCnt_q <= 5'h00;
      end else if (!countFull) begin
         bitCnt_q <= bitCnt_q + 5'h01;
      end
   end

   // shift register holds only data, so it needs no reset
   always_ff @(posedge sck) begin
      shift_q <= byteIn[6:0];
   end

   // opcode is staged so the published pair only changes together
   always_ff @(posedge sck or negedge rst_n) begin
      if (!rst_n) begin
         opcode_q  <= 8'h00;
         cmd       <= '0;
         cmdToggle <= 1'b0;
      end else if (opcodeDone) begin
         opcode_q  <= byteIn;
      end else if (dataDone) begin
         cmd       <= '{opcode: opcode_q, data: byteIn};
         cmdToggle <= ~cmdToggle;
      end
   end

endmodule

// ==== rtl/flash_param_regs.sv ====
// function register and read parameter register pair with the shared pin steering
// assumes commands arrive framed on sck and pins are asynchronous to clk
`timescale 1ns/1ps
module flash_param_regs (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic                        sck,
   input  wire logic                        csN,
   input  wire logic                        si,
   input  wire logic                        dedResetPkg,
   input  wire logic                        dedResetPinN,
   input  wire logic                        sharedPinN,
   input  wire logic                        quadLaneEnable,
   input  wire logic                        fourLaneCommandMode,
   input  wire logic                        suspendReq,
   input  wire logic                        resumeReq,
   input  wire logic                        programBusy,
   input  wire logic                        eraseBusy,
   input  flash_regs_pkg::read_kind_t       readKind,
   output flash_regs_pkg::func_reg_t        funcReg,
   output flash_regs_pkg::read_param_t      paramsPersist,
   output flash_regs_pkg::read_param_t      paramsActive,
   output logic                             sharedPinIsLane,
   output logic                             sharedPinIsHold,
   output logic                             sharedPinIsReset,
   output logic                             wpPinIsLane,
   output logic                             holdActive,
   output logic                             deviceResetReq,
   output logic [3:0]                       dummyCycleCount,
   output logic [6:0]                       wrapBoundaryBytes,
   output logic                             initDone
);

   // ----------------------------------------
   // link side and its crossing
   // ----------------------------------------
   flash_regs_pkg::link_cmd_t linkCmd;
   logic                      linkToggle;
   logic [1:0]                toggleSync_q;
   logic                      togglePrev_q;

   link_cmd_capture capture (
      .sck       (sck),
      .rst_n     (rst_n),
      .csN       (csN),
      .si        (si),
      .cmd       (linkCmd),
      .cmdToggle (linkToggle)
   );

   // toggle crossing; the pair is stable for a whole frame after each toggle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         toggleSync_q <= 2'b00;
         togglePrev_q <= 1'b0;
      end else begin
         toggleSync_q <= {toggleSync_q[0], linkToggle};
         togglePrev_q <= toggleSync_q[1];
      end
   end

   wire cmdEvt = (toggleSync_q[1] ^ togglePrev_q) & initDone;
   wire isPersist = cmdEvt & (linkCmd.opcode == flash_regs_pkg::OP_PARAMS_PERSIST);
   wire isTemp = cmdEvt & ((linkCmd.opcode == flash_regs_pkg::OP_PARAMS_TEMP_A)
                        | (linkCmd.opcode == flash_regs_pkg::OP_PARAMS_TEMP_B));
   wire isFuncWr = cmdEvt & (linkCmd.opcode == flash_regs_pkg::OP_WRITE_FUNC);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] pinSync1_q;
   logic [2:0] pinSync2_q;

   // pins idle high, so reset to the inactive level to avoid a false reset request
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pinSync1_q <= 3'b011;
         pinSync2_q <= 3'b011;
      end else begin
         pinSync1_q <= {dedResetPkg, sharedPinN, dedResetPinN};
         pinSync2_q <= pinSync1_q;
      end
   end

   wire dedPkg     = pinSync2_q[2];
   wire sharedLow  = ~pinSync2_q[1];
   wire dedPinLow  = ~pinSync2_q[0];

   // ----------------------------------------
   // power-up sequence
   // ----------------------------------------
   logic [1:0] initCnt_q;
   wire        initLast = (initCnt_q == flash_regs_pkg::INIT_CYCLES);

   // commands wait until the package strap has passed its synchroniser
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         initCnt_q <= 2'h0;
         initDone  <= 1'b0;
      end else if (!initLast) begin
         initCnt_q <= initCnt_q + 2'h1;
      end else begin
         initDone  <= 1'b1;
      end
   end

   // ----------------------------------------
   // function register
   // ----------------------------------------
   flash_regs_pkg::func_reg_t funcReg_d;
   wire [7:0] funcBits = funcReg;
   wire [7:0] otpSet = isFuncWr ? (linkCmd.data & flash_regs_pkg::FUNC_OTP_MASK) : 8'h00;
   // strap caught after release: parts without the dedicated pin read disabled
   wire [7:0] strapSet = (initLast & ~initDone & ~dedPkg) ? flash_regs_pkg::FUNC_RST_DIS
                                                          : 8'h00;
   wire [7:0] otpNext = (funcBits | otpSet | strapSet) & flash_regs_pkg::FUNC_OTP_MASK;
   // set wins over clear when suspend and resume meet
   wire progPause = (suspendReq & programBusy)
                  | (funcReg.programPausedFlag & ~resumeReq);
   wire erasePause = (suspendReq & eraseBusy)
                   | (funcReg.erasePausedFlag & ~resumeReq);

   assign funcReg_d = '{infoRowLock:           otpNext[7:4],
                        erasePausedFlag:       erasePause,
                        programPausedFlag:     progPause,
                        protectAreaSideSelect: otpNext[1],
                        resetPinDisable:       otpNext[0]};

   // one-time bits are modelled as flops cleared only at power-up
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         funcReg <= flash_regs_pkg::FUNC_RESET;
      end else begin
         funcReg <= funcReg_d;
      end
   end

   // ----------------------------------------
   // read parameter pair
   // ----------------------------------------
   wire flash_regs_pkg::read_param_t cmdParams = linkCmd.data;

   // each opcode touches its own copy only
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         paramsPersist <= flash_regs_pkg::PARAMS_RESET;
         paramsActive  <= flash_regs_pkg::PARAMS_RESET;
      end else begin
         if (isPersist) begin
            paramsPersist <= cmdParams;
         end
         if (!initDone) begin
            paramsActive <= paramsPersist;
         end else if (isTemp) begin
            paramsActive <= cmdParams;
         end
      end
   end

   // ----------------------------------------
   // shared pin steering
   // ----------------------------------------
   wire laneMode = quadLaneEnable | fourLaneCommandMode;
   wire dedActive = dedPkg & ~funcReg.resetPinDisable;
   // with the dedicated pin live the shared pin stays hold outside lane mode
   wire selReset = dedPkg ? (funcReg.resetPinDisable & paramsActive.sharedPinFunctionSelect)
                          : paramsActive.sharedPinFunctionSelect;
   wire holdSel = ~laneMode & ~selReset;
   wire resetSel = ~laneMode & selReset;
   wire resetReq = (dedActive & dedPinLow) | (resetSel & sharedLow);

   // ----------------------------------------
   // read behaviour decode
   // ----------------------------------------
   wire [3:0] kindDefault =
      (readKind == flash_regs_pkg::RK_DUAL_IO) ? flash_regs_pkg::DUMMY_DUAL_IO :
      ((readKind == flash_regs_pkg::RK_FAST_FOUR_LANE)
       | (readKind == flash_regs_pkg::RK_QUAD_IO)) ? flash_regs_pkg::DUMMY_QUAD :
      flash_regs_pkg::DUMMY_SINGLE;
   wire useDefault = (paramsActive.dummyCycles == flash_regs_pkg::DUMMY_USE_DEFAULT);
   wire [3:0] dummyNext = useDefault ? kindDefault : paramsActive.dummyCycles;
   wire [6:0] burstBytes = flash_regs_pkg::BURST_MIN_BYTES << paramsActive.burstLength;
   // zero means the read runs across the whole array
   wire [6:0] wrapNext = paramsActive.wrapEnable ? burstBytes
                                                 : flash_regs_pkg::WRAP_WHOLE_ARRAY;

   // outputs are registered so pin steering never glitches
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sharedPinIsLane   <= 1'b0;
         sharedPinIsHold   <= 1'b1;
         sharedPinIsReset  <= 1'b0;
         wpPinIsLane       <= 1'b0;
         holdActive        <= 1'b0;
         deviceResetReq    <= 1'b0;
         dummyCycleCount   <= flash_regs_pkg::DUMMY_SINGLE;
         wrapBoundaryBytes <= flash_regs_pkg::WRAP_WHOLE_ARRAY;
      end else begin
         sharedPinIsLane   <= laneMode;
         sharedPinIsHold   <= holdSel;
         sharedPinIsReset  <= resetSel;
         wpPinIsLane       <= quadLaneEnable;
         holdActive        <= holdSel & sharedLow;
         deviceResetReq    <= resetReq;
         dummyCycleCount   <= dummyNext;
         wrapBoundaryBytes <= wrapNext;
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   // one-time bits may rise but never fall once the power-up sequence is over
   a_otp_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      initDone |=> (($past(funcBits) & ~funcBits & flash_regs_pkg::FUNC_OTP_MASK) == 8'h00))
      else $error("one-time bit returned to zero");
   a_otp_no_clear: assert property (@(posedge clk) disable iff (!rst_n)
      (initDone && funcReg.resetPinDisable) |=> funcReg.resetPinDisable)
      else $error("reset-disable bit returned to zero");
   a_strap_disable: assert property (@(posedge clk) disable iff (!rst_n)
      (initDone && !dedPkg) |-> funcReg.resetPinDisable)
      else $error("reset-disable bit clear without dedicated pin");
   a_side_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      funcReg.protectAreaSideSelect |=> funcReg.protectAreaSideSelect [*2])
      else $error("bottom selection reverted");
   a_lock_sticky: assert property (@(posedge clk) disable iff (!rst_n)
      (isFuncWr && linkCmd.data[7]) |=> funcReg.infoRowLock[3] ##1 funcReg.infoRowLock[3])
      else $error("info row lock not held");
   a_prog_pause: assert property (@(posedge clk) disable iff (!rst_n)
      (suspendReq && programBusy) |=> funcReg.programPausedFlag)
      else $error("program paused flag not set");
   a_prog_resume: assert property (@(posedge clk) disable iff (!rst_n)
      (resumeReq && !suspendReq && funcReg.programPausedFlag) |=> !funcReg.programPausedFlag)
      else $error("program paused flag not cleared");
   a_erase_pause: assert property (@(posedge clk) disable iff (!rst_n)
      (suspendReq && eraseBusy) |=> funcReg.erasePausedFlag)
      else $error("erase paused flag not set");
   a_erase_resume: assert property (@(posedge clk) disable iff (!rst_n)
      (resumeReq && !suspendReq && funcReg.erasePausedFlag) |=> !funcReg.erasePausedFlag)
      else $error("erase paused flag not cleared");
   a_power_load: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(initDone) |-> (paramsActive == paramsPersist))
      else $error("working copy not loaded at power-up");
   a_persist_only: assert property (@(posedge clk) disable iff (!rst_n)
      isPersist |=> (paramsPersist == $past(cmdParams)) && $stable(paramsActive))
      else $error("persistent write touched wrong copy");
   a_temp_only: assert property (@(posedge clk) disable iff (!rst_n)
      isTemp |=> (paramsActive == $past(cmdParams)) && $stable(paramsPersist))
      else $error("temporary write touched wrong copy");
   a_lane_mode: assert property (@(posedge clk) disable iff (!rst_n)
      (quadLaneEnable || fourLaneCommandMode) |=> sharedPinIsLane && !sharedPinIsHold
                                               && !sharedPinIsReset)
      else $error("shared pin not a data lane");
   a_wp_lane: assert property (@(posedge clk) disable iff (!rst_n)
      quadLaneEnable |=> wpPinIsLane)
      else $error("write-protect pin not a data lane");
   a_hold_forced: assert property (@(posedge clk) disable iff (!rst_n)
      (dedPkg && !funcReg.resetPinDisable && !laneMode) |=> sharedPinIsHold)
      else $error("shared pin not forced to hold");
   a_reset_moved: assert property (@(posedge clk) disable iff (!rst_n)
      (dedPkg && funcReg.resetPinDisable && !laneMode && paramsActive.sharedPinFunctionSelect)
      |=> sharedPinIsReset && !sharedPinIsHold)
      else $error("reset function not moved to shared pin");
   a_ded_ignored: assert property (@(posedge clk) disable iff (!rst_n)
      (dedPkg && funcReg.resetPinDisable && dedPinLow && !sharedLow) |=> !deviceResetReq)
      else $error("disabled dedicated pin still resets");
   a_pin_select: assert property (@(posedge clk) disable iff (!rst_n)
      (!dedPkg && !laneMode) |=> sharedPinIsReset == $past(paramsActive.sharedPinFunctionSelect))
      else $error("shared pin function mismatch");
   a_dummy_count: assert property (@(posedge clk) disable iff (!rst_n)
      !useDefault |=> dummyCycleCount == $past(paramsActive.dummyCycles))
      else $error("dummy count not from field");
   a_dummy_default: assert property (@(posedge clk) disable iff (!rst_n)
      (useDefault && readKind == flash_regs_pkg::RK_DUAL_IO) |=> dummyCycleCount == 4'h4)
      else $error("dual io default dummy wrong");
   a_wrap_bytes: assert property (@(posedge clk) disable iff (!rst_n)
      (paramsActive.wrapEnable && paramsActive.burstLength == 2'b11)
      |=> wrapBoundaryBytes == 7'h40)
      else $error("burst boundary wrong");

   // main scenarios the bench is expected to reach
   c_temp_write: cover property (@(posedge clk) disable iff (!rst_n) isTemp);
   c_reset_req: cover property (@(posedge clk) disable iff (!rst_n) deviceResetReq);
   c_persist_write: cover property (@(posedge clk) disable iff (!rst_n) isPersist);
   c_func_write: cover property (@(posedge clk) disable iff (!rst_n) isFuncWr);
   c_pause_resume: cover property (@(posedge clk) disable iff (!rst_n)
      funcReg.programPausedFlag ##[1:50] !funcReg.programPausedFlag);

endmodule

// ==== verification/spi_host_model.sv ====
// host model for the serial command link: sends one opcode and one data byte per frame
// assumes the caller spaces frames by at least four system clocks
`timescale 1ns/1ps
module spi_host_model (
   output logic sck,
   output logic csN,
   output logic si
);
   // ---------------------------------
   // frame sender
   // ---------------------------------
   // sck stands low outside frames; released si shows the inverse of its last bit
   initial begin
      sck = 1'b0;
      csN = 1'b1;
      si  = 1'b0;
   end

   // opcode byte then data byte, msb first, mode 0 timing at 15 ns per bit
   task automatic sendCmd(input logic [7:0] op, input logic [7:0] dat);
      logic [15:0] frame;
      frame = {op, dat};
      csN = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         si = frame[i];
         #7.5 sck = 1'b1;
         #7.5 sck = 1'b0;
      end
      #7.5 csN = 1'b1; // one command per frame
      si = ~si;
   endtask
endmodule

// ==== verification/tb_flash_param_regs.sv ====
// self-checking bench for the function and read parameter registers
// assumes the host model drives the link and the bench drives the clk-domain inputs
`timescale 1ns/1ps
module tb_flash_param_regs;
   // ---------------------------------
   // signals and instances
   // ---------------------------------
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sck, csN, si;
   logic dedResetPkg = 1'b1;
   logic dedResetPinN = 1'b1;
   logic sharedPinN = 1'b1;
   logic quadLaneEnable = 1'b0;
   logic fourLaneCommandMode = 1'b0;
   logic suspendReq = 1'b0;
   logic resumeReq = 1'b0;
   logic programBusy = 1'b0;
   logic eraseBusy = 1'b0;
   flash_regs_pkg::read_kind_t readKind = flash_regs_pkg::RK_FAST_SINGLE;
   flash_regs_pkg::func_reg_t funcReg;
   flash_regs_pkg::read_param_t paramsPersist, paramsActive;
   logic sharedPinIsLane, sharedPinIsHold, sharedPinIsReset;
   logic wpPinIsLane, holdActive, deviceResetReq, initDone;
   logic [3:0] dummyCycleCount;
   logic [6:0] wrapBoundaryBytes;
   int fails = 0;
   int compares = 0;
   logic [3:0] dflt [6] = '{4'h8, 4'h6, 4'h8, 4'h4, 4'h8, 4'h6};

   spi_host_model host (.sck(sck), .csN(csN), .si(si));

   flash_param_regs DUT (
      .clk(clk), .rst_n(rst_n), .sck(sck), .csN(csN), .si(si),
      .dedResetPkg(dedResetPkg), .dedResetPinN(dedResetPinN),
      .sharedPinN(sharedPinN), .quadLaneEnable(quadLaneEnable),
      .fourLaneCommandMode(fourLaneCommandMode), .suspendReq(suspendReq),
      .resumeReq(resumeReq), .programBusy(programBusy), .eraseBusy(eraseBusy),
      .readKind(readKind), .funcReg(funcReg), .paramsPersist(paramsPersist),
      .paramsActive(paramsActive), .sharedPinIsLane(sharedPinIsLane),
      .sharedPinIsHold(sharedPinIsHold), .sharedPinIsReset(sharedPinIsReset),
      .wpPinIsLane(wpPinIsLane), .holdActive(holdActive),
      .deviceResetReq(deviceResetReq), .dummyCycleCount(dummyCycleCount),
      .wrapBoundaryBytes(wrapBoundaryBytes), .initDone(initDone)
   );

   // ---------------------------------
   // helpers
   // ---------------------------------
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end

   always #10 clk = ~clk;

   // sample one ns past the edge so that edge's updates have landed
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // a command lands 3-4 clocks after its last bit, derived outputs one later
   task automatic cmd(input logic [7:0] op, input logic [7:0] dat);
      host.sendCmd(op, dat);
      wt(8);
   endtask

   task automatic pulse(input bit sus);
      @(posedge clk);
      if (sus) suspendReq <= 1'b1; else resumeReq <= 1'b1;
      @(posedge clk);
      suspendReq <= 1'b0;
      resumeReq <= 1'b0;
      wt(2);
   endtask

   task automatic print_verdict;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // a hang past the expected run length counts as a mismatch
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      print_verdict;
   end

   // ---------------------------------
   // test sequence
   // ---------------------------------
   initial begin
      wt(8);
      rst_n <= 1'b1;
      wt(8);
      `CHK(initDone, 1'b1)
      `CHK(funcReg, 8'h00)
      `CHK(paramsActive, 8'h00)
      `CHK(dummyCycleCount, 4'h8)
      `CHK(wrapBoundaryBytes, 7'h00)
      $display("defaults done");
      cmd(8'h65, 8'h55);
      `CHK(paramsPersist, 8'h55)
      `CHK(paramsActive, 8'h00)
      cmd(8'hC0, 8'h2A);
      `CHK(paramsActive, 8'h2A)
      `CHK(paramsPersist, 8'h55)
      for (int b = 0; b < 4; b++) begin
         cmd(8'hC0, {1'b0, 4'h3, 1'b1, b[1:0]});
         `CHK(wrapBoundaryBytes, 7'h08 << b)
         `CHK(dummyCycleCount, 4'h3)
      end
      cmd(8'h63, 8'h7B);
      `CHK(wrapBoundaryBytes, 7'h00)
      `CHK(dummyCycleCount, 4'hF)
      cmd(8'hC0, 8'h00);
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         readKind <= flash_regs_pkg::read_kind_t'(k);
         wt(3);
         `CHK(dummyCycleCount, dflt[k])
      end
      $display("read parameters done");
      programBusy <= 1'b1;
      pulse(1'b1);
      `CHK(funcReg.programPausedFlag, 1'b1)
      pulse(1'b0);
      `CHK(funcReg.programPausedFlag, 1'b0)
      programBusy <= 1'b0;
      eraseBusy <= 1'b1;
      pulse(1'b1);
      `CHK(funcReg.erasePausedFlag, 1'b1)
      pulse(1'b0);
      `CHK(funcReg.erasePausedFlag, 1'b0)
      eraseBusy <= 1'b0;
      $display("suspend flags done");
      cmd(8'hC0, 8'h80);
      `CHK(sharedPinIsHold, 1'b1)
      `CHK(sharedPinIsReset, 1'b0)
      dedResetPinN <= 1'b0;
      wt(4);
      `CHK(deviceResetReq, 1'b1)
      dedResetPinN <= 1'b1;
      quadLaneEnable <= 1'b1;
      wt(4);
      `CHK(sharedPinIsLane, 1'b1)
      `CHK(wpPinIsLane, 1'b1)
      quadLaneEnable <= 1'b0;
      wt(4);
      `CHK(wpPinIsLane, 1'b0)
      cmd(8'h42, 8'h02);
      `CHK(funcReg, 8'h02)
      cmd(8'h42, 8'hF0);
      `CHK(funcReg, 8'hF2)
      cmd(8'h42, 8'h00);
      `CHK(funcReg, 8'hF2)
      cmd(8'h42, 8'hFF);
      `CHK(funcReg, 8'hF3)
      `CHK(sharedPinIsReset, 1'b1)
      dedResetPinN <= 1'b0;
      wt(4);
      `CHK(deviceResetReq, 1'b0)
      dedResetPinN <= 1'b1;
      sharedPinN <= 1'b0;
      wt(4);
      `CHK(deviceResetReq, 1'b1)
      sharedPinN <= 1'b1;
      fourLaneCommandMode <= 1'b1;
      wt(4);
      `CHK(sharedPinIsLane, 1'b1)
      fourLaneCommandMode <= 1'b0;
      cmd(8'hC0, 8'h00);
      `CHK(sharedPinIsHold, 1'b1)
      sharedPinN <= 1'b0;
      wt(4);
      `CHK(holdActive, 1'b1)
      sharedPinN <= 1'b1;
      $display("function register and pins done");
      // second power-up on a part without the dedicated reset pin
      @(posedge clk);
      rst_n <= 1'b0;
      dedResetPkg <= 1'b0;
      wt(8);
      rst_n <= 1'b1;
      wt(8);
      `CHK(initDone, 1'b1)
      `CHK(funcReg, 8'h01)
      `CHK(paramsActive, 8'h00)
      cmd(8'hC0, 8'h80);
      `CHK(sharedPinIsReset, 1'b1)
      `CHK(sharedPinIsHold, 1'b0)
      sharedPinN <= 1'b0;
      wt(4);
      `CHK(deviceResetReq, 1'b1)
      sharedPinN <= 1'b1;
      $display("second power-up done");
      print_verdict;
   end
endmodule
